// *** rtl/brc_map.vh ***
// brownout reset control: register map, field positions, reset values
// and timing counts shared by the design files
// assumes a 10 MHz pclk and 32-bit apb data
`ifndef BRC_MAP_VH
`define BRC_MAP_VH

// ==========================================================
// register byte offsets
`define BRC_CTRL_OFS        12'h000
`define BRC_STAT_OFS        12'h004
`define BRC_CAUSE_OFS       12'h008

// ==========================================================
// control register fields
`define BRC_CTRL_SWEN_BIT   0
`define BRC_CTRL_MODE_LSB   1
`define BRC_CTRL_LVL_LSB    3
`define BRC_CTRL_POWERUP_TIMER_BIT   5
`define BRC_CTRL_PIN_BIT    6
`define BRC_CTRL_STK_BIT    7
`define BRC_CTRL_RST        8'hC6

// ==========================================================
// brownout modes
`define BRC_MODE_OFF        2'h0
`define BRC_MODE_SW         2'h1
`define BRC_MODE_AWAKE      2'h2
`define BRC_MODE_ON         2'h3

// ==========================================================
// reset cause bits
`define BRC_CS_POR          0
`define BRC_CS_BOR          1
`define BRC_CS_LOW_POWER_SUPPLY_DIP_RESET        2
`define BRC_CS_PIN          3
`define BRC_CS_WDT          4
`define BRC_CS_INSTR        5
`define BRC_CS_OVF          6
`define BRC_CS_UNF          7
`define BRC_CS_PROG         8
`define BRC_CS_W            9

// ==========================================================
// timing
`define BRC_CLK_PERIOD_NS   100
`define BRC_DIP_FILTER_NS   1000
`define BRC_POWERUP_TIMER_LF_CYCLES  2048
`define BRC_PIN_RELEASE_CYC 10

`endif

// *** rtl/brc_reset_ctrl.v ***
// brownout reset control: gathers reset sources, runs the power-up
// timer and brownout modes, and holds the core in reset
// assumes analog monitors and reset pin arrive asynchronously, core
// events arrive on pclk, and apb master on pclk
`timescale 1ns/1ns
`default_nettype none
`include "brc_map.vh"

// Notes on behaviour
// - reset on power, dips, pin, watchdog, instr, stack, prog exit.
// - optional power-up timer stretches reset after power or brownout.
// - hold reset while the power-on supply-good indication is low.
// - brownout holds reset while supply low; level chosen by two bits.
// - four brownout modes: on, off in sleep, software, off.
// - brownout trips only when low supply persists past filter time.
// - mode 11 always active; start-up waits for ready and good supply.
// - mode 11 protects in sleep; wake-up is not delayed.
// - mode 10 active awake, hibernates asleep; start-up waits ready.
// - mode 10 unprotected asleep; wake-up waits for detector ready.
// - mode 01 uses software enable; start-up does not wait.
// - mode 01 protects once ready; ready flag readable; sleep no effect.
// - power-up timer counts 2048 slow oscillator edges after release.
// - run after timers done and pin released, plus ten cycles.
// - low-power brownout request ORs into combined brownout reset.
module brc_reset_ctrl #(
  parameter POWERUP_TIMER_LF_CYCLES = `BRC_POWERUP_TIMER_LF_CYCLES,
  parameter DIP_FILTER_NS  = `BRC_DIP_FILTER_NS,
  parameter CLK_PERIOD_NS  = `BRC_CLK_PERIOD_NS,
  parameter PIN_CYC        = `BRC_PIN_RELEASE_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        por_supply_good,
  input  wire        supply_below_level,
  input  wire        detector_ready,
  input  wire        low_power_supply_dip_reset,
  input  wire        external_reset_pin_n,
  input  wire        low_freq_internal_osc,
  input  wire        osc_startup_done,
  input  wire        watchdog_reset,
  input  wire        reset_instr,
  input  wire        stack_overflow,
  input  wire        stack_underflow,
  input  wire        prog_mode_exit,
  input  wire        sleep_active,
  output reg         core_reset_n_q,
  output reg         detector_enable_q,
  output reg  [1:0]  brownout_level_sel_q,
  output reg         protect_active_q,
  output reg         wake_ready_q
);

  // ==========================================================
  // derived counts
  localparam FILT_CYC_I = (DIP_FILTER_NS + CLK_PERIOD_NS - 1)
                          / CLK_PERIOD_NS;
  localparam FILT_CYC   = (FILT_CYC_I < 1) ? 1 : FILT_CYC_I;
  localparam [7:0]  FILT_MAX = FILT_CYC[7:0];
  localparam POWERUP_TIMER_M1 = POWERUP_TIMER_LF_CYCLES - 1;
  localparam PIN_M1  = PIN_CYC - 1;
  localparam [11:0] POWERUP_TIMER_MAX = POWERUP_TIMER_M1[11:0];
  localparam [3:0]  PIN_MAX  = PIN_M1[3:0];

  // ==========================================================
  // sequencer states
  localparam [2:0] ST_HOLD  = 3'h0;
  localparam [2:0] ST_POWERUP_TIMER  = 3'h1;
  localparam [2:0] ST_READY = 3'h2;
  localparam [2:0] ST_PIN   = 3'h3;
  localparam [2:0] ST_RUN   = 3'h4;

  // ==========================================================
  // mode decoding
  function start_waits;
    input [1:0] mode;
    begin
      start_waits = (mode == `BRC_MODE_ON) ||
                    (mode == `BRC_MODE_AWAKE);
    end
  endfunction

  function det_enabled;
    input [1:0] mode;
    input       sleep;
    input       swen;
    begin
      case (mode)
        `BRC_MODE_ON:    det_enabled = 1'b1;
        `BRC_MODE_AWAKE: det_enabled = !sleep;
        `BRC_MODE_SW:    det_enabled = swen;
        default:         det_enabled = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // synchronised pins
  wire [5:0] pins_s;
  wire       por_good_s;
  wire       low_s;
  wire       ready_s;
  wire       lp_dip_s;
  wire       pin_n_s;
  wire       lfosc_s;

  brc_sync2 #(
    .WIDTH (6)
  ) brc_sync2_inst (
    .clk      (pclk),
    .rst_n    (presetn),
    .async_in ({low_freq_internal_osc, external_reset_pin_n,
                low_power_supply_dip_reset, detector_ready,
                supply_below_level, por_supply_good}),
    .sync_q   (pins_s)
  );

  assign por_good_s = pins_s[0];
  assign low_s      = pins_s[1];
  assign ready_s    = pins_s[2];
  assign lp_dip_s   = pins_s[3];
  assign pin_n_s    = pins_s[4];
  assign lfosc_s    = pins_s[5];

  // ==========================================================
  // registers
  reg  [7:0]          ctrl_q;
  reg  [`BRC_CS_W-1:0] cause_q;
  reg  [`BRC_CS_W-1:0] cause_d;
  reg  [2:0]          state_q;
  reg  [2:0]          state_d;
  reg  [7:0]          filt_q;
  reg                 bor_trip_q;
  reg  [11:0]         powerup_timer_q;
  reg  [3:0]          pin_cnt_q;
  reg                 lfosc_q;
  reg                 sleep_q;

  wire       swen     = ctrl_q[`BRC_CTRL_SWEN_BIT];
  wire [1:0] mode     = ctrl_q[`BRC_CTRL_MODE_LSB+1:`BRC_CTRL_MODE_LSB];
  wire [1:0] level    = ctrl_q[`BRC_CTRL_LVL_LSB+1:`BRC_CTRL_LVL_LSB];
  wire       powerup_timer_en  = ctrl_q[`BRC_CTRL_POWERUP_TIMER_BIT];
  wire       pin_en   = ctrl_q[`BRC_CTRL_PIN_BIT];
  wire       stk_en   = ctrl_q[`BRC_CTRL_STK_BIT];

  // ==========================================================
  // brownout protection and filter
  wire det_en  = det_enabled(mode, sleep_active, swen);
  // mode 01 protects only once the detector is ready
  wire protect = det_en &&
                 ((mode != `BRC_MODE_SW) || ready_s);
  // sleep drops protection only in mode 10
  wire bor_req = bor_trip_q;
  wire dip_any = bor_req || lp_dip_s;
  wire pin_low = pin_en && !pin_n_s;
  wire power_fault = !por_good_s || dip_any;
  wire lf_tick = lfosc_s && !lfosc_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_q     <= 8'h00;
      bor_trip_q <= 1'b0;
    end else begin
      if (protect && low_s) begin
        if (filt_q != FILT_MAX) begin
          filt_q <= filt_q + 8'h01;
        end
        bor_trip_q <= (filt_q == FILT_MAX);
      end else begin
        filt_q     <= 8'h00;
        bor_trip_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // soft reset sources while running
  wire soft_rst = watchdog_reset || reset_instr || pin_low ||
                  (stk_en && (stack_overflow || stack_underflow));

  // ==========================================================
  // sequencer
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_HOLD: begin
        if (!power_fault) begin
          state_d = powerup_timer_en ? ST_POWERUP_TIMER : ST_READY;
        end
      end
      ST_POWERUP_TIMER: begin
        if (lf_tick && powerup_timer_q == POWERUP_TIMER_MAX) begin
          state_d = ST_READY;
        end
      end
      ST_READY: begin
        if (osc_startup_done &&
            (!start_waits(mode) || (ready_s && !low_s))) begin
          state_d = ST_PIN;
        end
      end
      ST_PIN: begin
        if (!pin_low && pin_cnt_q == PIN_MAX) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (soft_rst) begin
          state_d = ST_PIN;
        end
      end
      default: state_d = ST_HOLD;
    endcase
    if (power_fault || prog_mode_exit) begin
      state_d = ST_HOLD;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= ST_HOLD;
      powerup_timer_q    <= 12'h000;
      pin_cnt_q <= 4'h0;
      lfosc_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      lfosc_q <= lfosc_s;
      if (state_q != ST_POWERUP_TIMER) begin
        powerup_timer_q <= 12'h000;
      end else if (lf_tick) begin
        powerup_timer_q <= powerup_timer_q + 12'h001;
      end
      if (state_q != ST_PIN || pin_low || soft_rst) begin
        pin_cnt_q <= 4'h0;
      end else if (pin_cnt_q != PIN_MAX) begin
        pin_cnt_q <= pin_cnt_q + 4'h1;
      end
    end
  end

  // ==========================================================
  // apb write decode, shared by control and cause registers
  wire wr_done = psel && penable && pready && pwrite;

  function addr_hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  // ==========================================================
  // reset cause flags, set wins over clear
  wire cause_wr = wr_done && addr_hit(paddr, `BRC_CAUSE_OFS);

  always @* begin
    cause_d = cause_q;
    if (cause_wr) begin
      cause_d = cause_q & ~pwdata[`BRC_CS_W-1:0];
    end
    if (!por_good_s)                 cause_d[`BRC_CS_POR]   = 1'b1;
    if (bor_req)                     cause_d[`BRC_CS_BOR]   = 1'b1;
    if (lp_dip_s)                    cause_d[`BRC_CS_LOW_POWER_SUPPLY_DIP_RESET] = 1'b1;
    if (pin_low)                     cause_d[`BRC_CS_PIN]   = 1'b1;
    if (watchdog_reset)              cause_d[`BRC_CS_WDT]   = 1'b1;
    if (reset_instr)                 cause_d[`BRC_CS_INSTR] = 1'b1;
    if (stk_en && stack_overflow)    cause_d[`BRC_CS_OVF]   = 1'b1;
    if (stk_en && stack_underflow)   cause_d[`BRC_CS_UNF]   = 1'b1;
    if (prog_mode_exit)              cause_d[`BRC_CS_PROG]  = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= {`BRC_CS_W{1'b0}};
    end else begin
      cause_q <= cause_d;
    end
  end

  // ==========================================================
  // block outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset_n_q       <= 1'b0;
      detector_enable_q    <= 1'b0;
      brownout_level_sel_q <= 2'h0;
      protect_active_q     <= 1'b0;
      wake_ready_q         <= 1'b0;
      sleep_q              <= 1'b0;
    end else begin
      core_reset_n_q       <= (state_d == ST_RUN);
      detector_enable_q    <= det_en;
      brownout_level_sel_q <= level;
      protect_active_q     <= protect;
      sleep_q              <= sleep_active;
      // mode 10 wake waits for ready, other modes wake at once
      wake_ready_q <= (mode != `BRC_MODE_AWAKE) ||
                      ready_s;
    end
  end

  // ==========================================================
  // apb slave, one wait state
  wire acc  = psel && penable && !pready;
  wire [31:0] stat_word = {24'h000000, 3'h0, sleep_q, state_q,
                           ready_s && det_en};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= `BRC_CTRL_RST;
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (acc) begin
        case (paddr)
          `BRC_CTRL_OFS:  prdata <= {24'h000000, ctrl_q};
          `BRC_STAT_OFS:  prdata <= stat_word;
          `BRC_CAUSE_OFS: prdata <= {23'h000000, cause_q};
          default:        pslverr <= 1'b1;
        endcase
      end
      if (wr_done && addr_hit(paddr, `BRC_CTRL_OFS)) begin
        ctrl_q <= pwdata[7:0];
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/brc_sync2.v ***
// brownout reset control: two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/1ns
`default_nettype none

module brc_sync2 #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_q
);

  reg [WIDTH-1:0] meta_q;

  // ==========================================================
  // first stage is read only by the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

endmodule

`default_nettype wire

// *** test/brc_reset_ctrl_assertions.sv ***
// checker on the reset controller ports
// bound to the design from the bench top file
`timescale 1ns/1ns
`default_nettype none
module brc_reset_ctrl_assertions #(
  parameter DIP_FILTER_NS = 1000,
  parameter CLK_PERIOD_NS = 100,
  parameter PIN_CYC       = 10
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        por_supply_good,
  input wire logic        supply_below_level,
  input wire logic        external_reset_pin_n,
  input wire logic        osc_startup_done,
  input wire logic        watchdog_reset,
  input wire logic        protect_active_q,
  input wire logic        core_reset_n_q
);
  localparam int TRIP = DIP_FILTER_NS / CLK_PERIOD_NS + 8;
  logic [7:0] low_cnt_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =====
  // cycles of protected low supply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt_q <= 8'h00;
    else if (supply_below_level && protect_active_q)
      low_cnt_q <= low_cnt_q + 8'h01;
    else low_cnt_q <= 8'h00;
  end
  sequence s_take;
    psel && penable && !pready;
  endsequence
  sequence s_short_dip;
    core_reset_n_q && !supply_below_level ##1 supply_below_level [*3]
      ##1 !supply_below_level [*8];
  endsequence
  // =====
  // properties
  a_apb_answer: assert property (s_take |=> pready)
    else $error("access not answered one cycle later");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_addr_error: assert property (pready && !(paddr inside {12'h000,
    12'h004, 12'h008}) |-> pslverr) else $error("unmapped without error");
  a_por_hold: assert property (
    (!por_supply_good) [*6] |-> !core_reset_n_q)
    else $error("core released with supply bad");
  a_dip_trip: assert property (
    low_cnt_q == TRIP |-> !core_reset_n_q)
    else $error("long dip did not reset");
  a_short_dip: assert property (s_short_dip |-> core_reset_n_q)
    else $error("short dip reset the core");
  a_wdt_reset: assert property (
    core_reset_n_q && watchdog_reset |-> ##[1:3] !core_reset_n_q)
    else $error("watchdog ignored");
  a_pin_gap: assert property (
    $rose(core_reset_n_q) |-> $past(external_reset_pin_n, PIN_CYC))
    else $error("released too soon after pin");
  a_osc_gate: assert property (
    $rose(core_reset_n_q) |-> $past(osc_startup_done))
    else $error("released before osc");
  a_pin_hold: assert property (
    (!external_reset_pin_n) [*6] |-> !core_reset_n_q)
    else $error("pin low not holding reset");
endmodule
`default_nettype wire

// *** test/brc_reset_ctrl_tb.sv ***
// self-checking bench for the reset controller
// apb and core events from here; supply and pin from the model
`timescale 1ns/1ns
`default_nettype none
`include "brc_map.vh"
module brc_reset_ctrl_tb;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, core_reset_n_q, detector_enable_q;
  logic [1:0]  brownout_level_sel_q;
  logic        protect_active_q, wake_ready_q, por_supply_good;
  logic        supply_below_level, detector_ready, external_reset_pin_n;
  logic        low_power_supply_dip_reset, low_freq_internal_osc;
  logic        good = 1'b0, low = 1'b0, lp = 1'b0, pin_n = 1'b1;
  logic        stall = 1'b1, osc_startup_done = 1'b0, sleep_active = 1'b0;
  logic [4:0]  src = 5'h00;
  int          n_mismatch = 0, samples_checked = 0;
  brc_reset_ctrl #(.POWERUP_TIMER_LF_CYCLES(4)) brc_reset_ctrl_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .por_supply_good, .supply_below_level,
    .detector_ready, .low_power_supply_dip_reset, .external_reset_pin_n,
    .low_freq_internal_osc, .osc_startup_done, .watchdog_reset(src[0]),
    .reset_instr(src[1]), .stack_overflow(src[2]),
    .stack_underflow(src[3]), .prog_mode_exit(src[4]), .sleep_active,
    .core_reset_n_q, .detector_enable_q, .brownout_level_sel_q,
    .protect_active_q, .wake_ready_q);
  brc_supply_model brc_supply_model_inst (
    .pclk, .detector_enable_q, .good_cmd(good), .low_cmd(low),
    .lp_cmd(lp), .pin_cmd_n(pin_n), .stall_ready(stall), .por_supply_good,
    .supply_below_level, .detector_ready, .low_power_supply_dip_reset,
    .external_reset_pin_n, .low_freq_internal_osc);
  initial forever #50 pclk = ~pclk;
  // =====
  // shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask
  task automatic wcore(input logic v, output int n);
    n = 0;
    while (core_reset_n_q !== v && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) chk(core_reset_n_q, v);
  endtask
  task automatic cause_is(input int b);
    logic [31:0] r;
    logic e;
    apb(1'b0, `BRC_CAUSE_OFS, 32'h0, r, e);
    chk(r[b], 1'b1);
    wr(`BRC_CAUSE_OFS, 32'h1FF);
  endtask
  // =====
  // scenarios
  task automatic t_startup;
    int n;
    logic [31:0] r;
    logic e;
    cyc(30);
    chk(core_reset_n_q, 1'b0);
    good <= 1'b1;
    stall <= 1'b0;
    cyc(60);
    chk(core_reset_n_q, 1'b0);
    stall <= 1'b1;
    cyc(20);
    osc_startup_done <= 1'b1;
    cyc(60);
    chk(core_reset_n_q, 1'b0);
    pin_n <= 1'b0;
    stall <= 1'b0;
    cyc(60);
    chk(core_reset_n_q, 1'b0);
    pin_n <= 1'b1;
    wcore(1'b1, n);
    chk(n >= 10, 1'b1);
    wr(`BRC_STAT_OFS, 32'h0);
    rd(`BRC_STAT_OFS, 32'h9);
    rd(`BRC_CTRL_OFS, 32'hC6);
    apb(1'b0, 12'h00C, 32'h0, r, e);
    chk(r, 32'h0);
    chk(e, 1'b1);
    wr(`BRC_CTRL_OFS, 32'hD6);
    cyc(2);
    chk(brownout_level_sel_q, 2'h2);
    wr(`BRC_CTRL_OFS, 32'hC6);
    wr(`BRC_CAUSE_OFS, 32'h1FF);
  endtask
  task automatic t_sources;
    int n;
    for (int i = 0; i < 5; i++) begin
      src <= 5'h01 << i;
      @(posedge pclk);
      src <= 5'h00;
      wcore(1'b0, n);
      wcore(1'b1, n);
      cause_is(`BRC_CS_WDT + i);
    end
    rd(`BRC_CAUSE_OFS, 32'h0);
  endtask
  task automatic t_dip;
    int n, n0, n1;
    low <= 1'b1;
    cyc(3);
    low <= 1'b0;
    cyc(20);
    chk(core_reset_n_q, 1'b1);
    low <= 1'b1;
    wcore(1'b0, n);
    chk(n >= 10, 1'b1);
    cyc(10);
    low <= 1'b0;
    wcore(1'b1, n0);
    cause_is(`BRC_CS_BOR);
    wr(`BRC_CTRL_OFS, 32'hE6);
    low <= 1'b1;
    wcore(1'b0, n);
    low <= 1'b0;
    wcore(1'b1, n1);
    chk(n1 > n0 + 20, 1'b1);
    wr(`BRC_CTRL_OFS, 32'hC6);
    lp <= 1'b1;
    wcore(1'b0, n);
    lp <= 1'b0;
    wcore(1'b1, n);
    cause_is(`BRC_CS_LOW_POWER_SUPPLY_DIP_RESET);
    pin_n <= 1'b0;
    cyc(30);
    pin_n <= 1'b1;
    wcore(1'b1, n);
    chk(n >= 10, 1'b1);
    cause_is(`BRC_CS_PIN);
  endtask
  task automatic t_modes;
    logic [11:0] tbl [7] = '{12'hC6F, 12'hC48, 12'hC47, 12'hC37, 12'hC3F,
                             12'hC21, 12'hC01};
    int n;
    for (int i = 0; i < 7; i++) begin
      wr(`BRC_CTRL_OFS, {24'h0, tbl[i][11:4]});
      sleep_active <= tbl[i][3];
      cyc(20);
      chk({detector_enable_q, protect_active_q, wake_ready_q},
          tbl[i][2:0]);
    end
    sleep_active <= 1'b0;
    stall <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      wr(`BRC_CTRL_OFS, (j == 0) ? 32'hC0 : 32'hC2);
      src <= 5'h10;
      @(posedge pclk);
      src <= 5'h00;
      wcore(1'b0, n);
      wcore(1'b1, n);
      chk(n < 40, 1'b1);
    end
    stall <= 1'b0;
    wr(`BRC_CTRL_OFS, 32'hC6);
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_startup;
    t_sources;
    t_dip;
    t_modes;
    complete_run;
  end
  initial begin
    #3000000;
    n_mismatch++;
    complete_run;
  end
endmodule
bind brc_reset_ctrl brc_reset_ctrl_assertions #(
  .DIP_FILTER_NS(DIP_FILTER_NS), .CLK_PERIOD_NS(CLK_PERIOD_NS),
  .PIN_CYC(PIN_CYC)) brc_reset_ctrl_assertions_inst (.*);
`default_nettype wire

// *** test/brc_supply_model.sv ***
// model of supply monitors, detector and reset pin
// follows bench commands on pclk; slow oscillator runs free
`timescale 1ns/1ns
`default_nettype none
module brc_supply_model #(
  parameter int READY_DLY = 6,
  parameter int OSC_HALF  = 4
) (
  input  wire logic pclk,
  input  wire logic detector_enable_q,
  input  wire logic good_cmd,
  input  wire logic low_cmd,
  input  wire logic lp_cmd,
  input  wire logic pin_cmd_n,
  input  wire logic stall_ready,
  output var  logic por_supply_good,
  output var  logic supply_below_level,
  output var  logic detector_ready,
  output var  logic low_power_supply_dip_reset,
  output var  logic external_reset_pin_n,
  output var  logic low_freq_internal_osc
);
  int rdy_cnt = 0;
  int osc_cnt = 0;
  initial begin
    por_supply_good = 1'b0;
    supply_below_level = 1'b0;
    detector_ready = 1'b0;
    low_power_supply_dip_reset = 1'b0;
    external_reset_pin_n = 1'b1;
    low_freq_internal_osc = 1'b0;
  end
  always @(posedge pclk) begin
    por_supply_good <= good_cmd;
    supply_below_level <= low_cmd;
    low_power_supply_dip_reset <= lp_cmd;
    external_reset_pin_n <= pin_cmd_n;
    // ready only some cycles after the detector is powered
    if (!detector_enable_q || stall_ready) rdy_cnt <= 0;
    else if (rdy_cnt < READY_DLY) rdy_cnt <= rdy_cnt + 1;
    detector_ready <= (rdy_cnt == READY_DLY);
    osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
    if (osc_cnt == OSC_HALF - 1)
      low_freq_internal_osc <= !low_freq_internal_osc;
  end
endmodule
`default_nettype wire
